// *** verif/fsp_remote.sv ***
`timescale 1ns/1ns
// ======================================================
// remote serial device: sends frames and collects what it hears
module fsp_remote #(
    parameter int BIT = 24
) (
    // clock
    input wire logic hclk,
    // line
    input wire logic line_in,
    output logic line_out
);
    logic [7:0] b;
    logic [7:0] got[$];
    initial line_out = 1'b1;
    // start low, lsb first, two stop bits high
    task automatic send(input logic [7:0] d);
        logic [10:0] f;
        f = {2'b11, d, 1'b0};
        for (int i = 0; i < 11; i++)
        begin
            line_out <= f[i];
            repeat (BIT) @(posedge hclk);
        end
    endtask
    // sample each bit near its middle; a low stop bit drops the byte
    always
    begin
        @(negedge line_in);
        repeat (BIT / 2) @(posedge hclk);
        for (int i = 0; i < 8; i++)
        begin
            repeat (BIT) @(posedge hclk);
            b[i] = line_in;
        end
        repeat (BIT) @(posedge hclk);
        if (line_in === 1'b1)
            got.push_back(b);
    end
endmodule

// *** verif/fsp_sva.sv ***
`timescale 1ns/1ns
// ======================================================
// bus, line and memory port checks
module fsp_sva (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // line and memory
    input wire logic serial_tx,
    input wire fsp_pkg::fsp_mem_cmd_s mem_cmd,
    input wire logic mem_gnt
);
    import fsp_pkg::*;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // taken address phases; the register index sits in haddr[17:2]
    wire take = hsel && hready && htrans[1];
    wire mapped = (haddr[17:6] == 12'hc07) && !haddr[2];
    a_bus_okay:
        assert property (hresp == 1'b0) else $error("response not okay");
    a_read_wait_one:
        assert property (take && !hwrite |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
    a_write_no_wait:
        assert property (take && hwrite |=> hreadyout) else $error("write stalled");
    a_unmapped_zero:
        assert property (take && !hwrite && !mapped |=> ##1 hrdata == 32'h0) else $error("unmapped read not zero");
    a_upper_zero:
        assert property (take && !hwrite |=> ##1 hrdata[31:16] == 16'h0) else $error("upper read bits set");
    // a stalled request may not wander while it waits
    a_mem_req_hold:
        assert property (mem_cmd.req && !mem_gnt |=> mem_cmd.req && $stable(mem_cmd)) else $error("request moved");
    a_mem_req_drop:
        assert property (mem_cmd.req && mem_gnt |=> !mem_cmd.req) else $error("request not dropped");
    a_line_idle_high:
        assert property ($rose(hresetn) |-> serial_tx) else $error("line not idle after reset");
    // legal divisors give at least 8 clocks a bit, so a start bit is never short
    a_start_bit_len:
        assert property ($fell(serial_tx) |-> !serial_tx [*8]) else $error("start bit too short");
endmodule
bind fsp_top fsp_sva fsp_sva_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata,
    .hreadyout, .hresp, .serial_tx, .mem_cmd, .mem_gnt);

// *** verif/fsp_top_test.sv ***
`timescale 1ns/1ns
// ======================================================
// register level tests of the serial port
module fsp_top_test;
    import fsp_pkg::*;
    logic hclk, hresetn, hsel, hwrite, serial_rx, serial_tx, mem_gnt, hreadyout, hresp, receive_event_line;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [7:0] mem_rdata;
    logic [15:0] rd;
    logic [7:0] wmem [256];
    fsp_mem_cmd_s mem_cmd;
    int error_cnt = 0;
    int samples_checked = 0;
    fsp_top fsp_top_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .serial_rx, .serial_tx, .mem_cmd, .mem_gnt,
        .mem_rdata, .receive_event_line);
    fsp_remote fsp_remote_i (.hclk, .line_in(serial_tx), .line_out(serial_rx));
    // clock, reset and a memory that grants one cycle late to exercise stalls
    initial
    begin
        hclk = 0;
        forever #50 hclk = ~hclk;
    end
    always @(posedge hclk)
    begin
        mem_gnt <= mem_cmd.req && !mem_gnt;
        mem_rdata <= mem_cmd.addr[7:0] ^ 8'h5a;
        // keep what block receive deposits so it can be checked later
        if (mem_cmd.req && mem_gnt && mem_cmd.we)
            wmem[mem_cmd.addr[7:0]] <= mem_cmd.wdata;
    end
    // wait for the slave, looking where hreadyout has settled
    // no cycle limit here: only the watchdog may end a stalled wait
    task automatic wait_rdy();
        while (hreadyout !== 1'b1)
            @(negedge hclk);
        @(posedge hclk);
    endtask
    task automatic ahb(input logic [15:0] idx, input logic w, input logic [15:0] d);
        haddr <= {14'h0, idx, 2'b00};
        hwrite <= w;
        htrans <= 2'b10;
        @(negedge hclk);
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= {16'h0, d};
        @(negedge hclk);
        wait_rdy();
        rd = hrdata[15:0];
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdc(input logic [15:0] idx, input logic [15:0] mask, input logic [15:0] exp);
        ahb(idx, 1'b0, 16'h0);
        chk(rd & mask, exp);
    endtask
    task automatic wait_got(input int n);
        for (int k = 0; k < 3000 && fsp_remote_i.got.size() < n; k++)
            @(posedge hclk);
    endtask
    task automatic finish_test();
        $display("mismatches %0d, checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // watchdog well beyond the expected run of some four thousand cycles
    initial
    begin
        repeat (30000) @(posedge hclk);
        error_cnt++;
        finish_test();
    end
    // main sequence
    initial
    begin
        {hsel, haddr, htrans, hwrite, hwdata} = '0;
        hresetn = 0;
        repeat (5) @(posedge hclk);
        hresetn <= 1;
        hsel <= 1;
        @(posedge hclk);
        rdc(FSP_IDX_DIV, 16'hffff, 16'h0017);
        rdc(FSP_IDX_GAP, 16'hffff, 16'h0009);
        rdc(16'hc071, 16'hffff, 16'h0000);
        ahb(FSP_IDX_DIV, 1'b1, 16'hffff);
        rdc(FSP_IDX_DIV, 16'hffff, 16'h1fff);
        ahb(FSP_IDX_DIV, 1'b1, 16'h0017);
        ahb(FSP_IDX_GAP, 1'b1, 16'h000a);
        rdc(FSP_IDX_GAP, 16'hffff, 16'h000a);
        $display("reset values done");
        ahb(FSP_IDX_CTRL, 1'b1, 16'h8220);
        rdc(FSP_IDX_CTRL, 16'h0010, 16'h0010);
        ahb(FSP_IDX_DATA, 1'b1, 16'h01a5);
        wait_got(1);
        chk({8'h0, fsp_remote_i.got.pop_front()}, 16'h00a5);
        $display("byte transmit done");
        fsp_remote_i.send(8'h3c);
        rdc(FSP_IDX_CTRL, 16'h0001, 16'h0001);
        chk({15'h0, receive_event_line}, 16'h0001);
        ahb(FSP_IDX_CTRL, 1'b1, 16'h8228);
        @(posedge hclk); // the write lands on the edge the task returns at
        chk({15'h0, receive_event_line}, 16'h0000);
        rdc(FSP_IDX_DATA, 16'h00ff, 16'h003c);
        rdc(FSP_IDX_CTRL, 16'h0001, 16'h0000);
        for (int i = 1; i <= 9; i++)
            fsp_remote_i.send(i[7:0]);
        rdc(FSP_IDX_CTRL, 16'h0007, 16'h0007);
        chk({15'h0, receive_event_line}, 16'h0001);
        ahb(FSP_IDX_CTRL, 1'b1, 16'h8024);
        rdc(FSP_IDX_CTRL, 16'h0004, 16'h0000);
        for (int i = 1; i <= 8; i++)
            rdc(FSP_IDX_DATA, 16'h00ff, i[15:0]);
        rdc(FSP_IDX_CTRL, 16'h0003, 16'h0000);
        $display("receive fifo done");
        ahb(FSP_IDX_TXBASE, 1'b1, 16'h0010);
        ahb(FSP_IDX_TXLEN, 1'b1, 16'h0001);
        wait_got(2);
        rdc(FSP_IDX_TXLEN, 16'hffff, 16'h03ff);
        rdc(FSP_IDX_TXBASE, 16'hffff, 16'h0010);
        chk({8'h0, fsp_remote_i.got.pop_front()}, 16'h004a);
        chk({8'h0, fsp_remote_i.got.pop_front()}, 16'h004b);
        rdc(FSP_IDX_CTRL, 16'h0080, 16'h0080);
        ahb(FSP_IDX_CTRL, 1'b1, 16'h80a0);
        rdc(FSP_IDX_CTRL, 16'h0080, 16'h0000);
        $display("block transmit done");
        ahb(FSP_IDX_RXBASE, 1'b1, 16'h0020);
        ahb(FSP_IDX_RXLEN, 1'b1, 16'h0001);
        fsp_remote_i.send(8'h11);
        rdc(FSP_IDX_RXLEN, 16'hffff, 16'h0000);
        fsp_remote_i.send(8'h22);
        rdc(FSP_IDX_RXLEN, 16'hffff, 16'h03ff);
        rdc(FSP_IDX_RXBASE, 16'hffff, 16'h0020);
        rdc(FSP_IDX_CTRL, 16'h0041, 16'h0040);
        chk({8'h0, wmem[8'h20]}, 16'h0011);
        chk({8'h0, wmem[8'h21]}, 16'h0022);
        $display("block receive done");
        finish_test();
    end
endmodule

// *** verilog/fsp_pkg.sv ***
// ==========================================================
// fast serial port constants and types
package fsp_pkg;

    // ======================================================
    // register indices; byte address is four times the index
    localparam logic [15:0] FSP_IDX_CTRL = 16'hc070;
    localparam logic [15:0] FSP_IDX_DIV = 16'hc072;
    localparam logic [15:0] FSP_IDX_GAP = 16'hc074;
    localparam logic [15:0] FSP_IDX_DATA = 16'hc076;
    localparam logic [15:0] FSP_IDX_RXBASE = 16'hc078;
    localparam logic [15:0] FSP_IDX_RXLEN = 16'hc07a;
    localparam logic [15:0] FSP_IDX_TXBASE = 16'hc07c;
    localparam logic [15:0] FSP_IDX_TXLEN = 16'hc07e;

    // ======================================================
    // values after reset and after block completion
    localparam logic [12:0] FSP_DIV_RST = 13'h0017;
    localparam logic [7:0] FSP_GAP_RST = 8'h09;
    localparam logic [15:0] FSP_CTRL_RST = 16'h0000;
    localparam logic [9:0] FSP_CNT_RST = 10'h000;
    localparam logic [9:0] FSP_CNT_DONE = 10'h3ff;

    // ======================================================
    // control and status bit positions
    localparam int FSP_CB_EN = 15;
    localparam int FSP_CB_RXIE = 9;
    localparam int FSP_CB_TXDONE = 7;
    localparam int FSP_CB_RXDONE = 6;
    localparam int FSP_CB_ONESTOP = 5;
    localparam int FSP_CB_TXRDY = 4;
    localparam int FSP_CB_PKT = 3;
    localparam int FSP_CB_OVF = 2;
    localparam int FSP_CB_PKTRDY = 1;
    localparam int FSP_CB_RXRDY = 0;
    // plain read/write control bits that are simply stored
    localparam logic [15:0] FSP_CTRL_RW_MASK = 16'hef28;

    // ======================================================
    // framing
    localparam int FSP_DIV_W = 13;
    localparam int FSP_CNT_W = 10;
    localparam int FSP_RXF_DEPTH = 8;
    localparam logic [7:0] FSP_GAP_BIAS = 8'h07;
    localparam logic [7:0] FSP_STOP_ONE = 8'h01;
    localparam logic [7:0] FSP_STOP_TWO = 8'h02;
    localparam logic [3:0] FSP_LAST_BIT = 4'h7;

    typedef enum logic [1:0] {
        FSP_IDLE = 2'b00,
        FSP_START = 2'b01,
        FSP_DATA = 2'b10,
        FSP_STOP = 2'b11
    } fsp_line_e;

    // byte-wide request toward on-chip memory
    typedef struct packed {
        logic req;
        logic we;
        logic [15:0] addr;
        logic [7:0] wdata;
    } fsp_mem_cmd_s;

endpackage

// *** verilog/fsp_top.sv ***
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/1ns
// Operation
// - bit 4 reads one when holding free
// - bit 3 selects packet or not-empty event
// - overflow flag set, cleared by writing one
// - bit 1 reads one when fifo full
// - bit 0 reads one when fifo nonempty
// - divisor resets to 0x0017
// - bit time is divisor plus one clocks
// - gap only applies in block transmit
// - gap field resets to 0x0009
// - idle between bytes is gap minus seven
// - data read returns next received byte
// - data write sends one byte
// - receive base sets block receive address
// - transmit base sets block fetch address
// - loading receive counter starts block receive
// - receive counter decrements per byte, readable
// - counter reads 0x03FF after completion
// - transmit counter starts, decrements, ends 0x03FF
// - enable bit 15 gates port operation
// - transmit done flag, cleared by writing one
// - stop bits from bit 5, receive tolerant
module fsp_top #(
    parameter int DIV_W = fsp_pkg::FSP_DIV_W,
    parameter int CNT_W = fsp_pkg::FSP_CNT_W,
    parameter int RXF_DEPTH = fsp_pkg::FSP_RXF_DEPTH
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // serial line
    input wire logic serial_rx,
    output logic serial_tx,
    // on-chip memory for block transfers
    output fsp_pkg::fsp_mem_cmd_s mem_cmd,
    input wire logic mem_gnt,
    input wire logic [7:0] mem_rdata,
    // receive event level
    output logic receive_event_line
);
    import fsp_pkg::*;

    localparam int PW = $clog2(RXF_DEPTH);
    localparam logic [PW:0] RXF_FULL = (PW+1)'(RXF_DEPTH);

    // ======================================================
    // declarations
    logic ph_act_q, ph_wr_q, rd_done_q;
    logic [15:0] ph_idx_q;
    logic wr_stb, rd_stb;
    logic [31:0] rd_val;
    logic [15:0] ctrl_q, ctrl_rd, wdat;
    logic [DIV_W-1:0] div_q;
    logic [7:0] gap_q, stop_bits;
    logic [15:0] rx_base_q, tx_base_q, rx_ptr_q, tx_ptr_q;
    logic [CNT_W-1:0] rx_cnt_q, tx_cnt_q;
    logic rx_act_q, tx_act_q;
    logic txdone_q, rxdone_q, ovf_q;
    logic port_on;
    logic [7:0] rxf_mem [RXF_DEPTH];
    logic [PW-1:0] rxf_rd_q, rxf_wr_q;
    logic [PW:0] rxf_cnt_q;
    logic rxf_full, rxf_empty, rxf_push, rxf_pop, cpu_pop;
    logic hold_full_q, hold_blk_q;
    logic [7:0] hold_data_q;
    logic tx_busy, launch;
    logic rd_pend_q, mem_wr_done, mem_rd_done;
    fsp_line_e rx_state_q;
    logic [DIV_W-1:0] rx_timer_q;
    logic [3:0] rx_bit_q;
    logic [7:0] rx_shift_q, rx_byte_q;
    logic rx_got_q;

    // ======================================================
    // ahb-lite slave: writes take no wait, reads take one
    // a read waits one cycle so hrdata comes from a flop and a
    // write just before it is already visible
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ph_act_q <= 1'b0;
            ph_wr_q <= 1'b0;
            ph_idx_q <= 16'h0000;
        end
        else if (hready)
        begin
            ph_act_q <= hsel && htrans[1];
            ph_wr_q <= hwrite;
            ph_idx_q <= haddr[17:2];
        end
    end

    assign wr_stb = ph_act_q && ph_wr_q;
    assign rd_stb = ph_act_q && !ph_wr_q && !rd_done_q;
    assign hreadyout = !rd_stb;
    assign hresp = 1'b0;
    assign wdat = hwdata[15:0];

    // read data flop, captured in the wait cycle
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rd_done_q <= 1'b0;
            hrdata <= 32'h0000_0000;
        end
        else
        begin
            rd_done_q <= rd_stb;
            if (rd_stb)
                hrdata <= rd_val;
        end
    end

    // control/status image; flow-control status reads zero
    always_comb
    begin
        ctrl_rd = ctrl_q & FSP_CTRL_RW_MASK;
        ctrl_rd[FSP_CB_TXDONE] = txdone_q;
        ctrl_rd[FSP_CB_RXDONE] = rxdone_q;
        ctrl_rd[FSP_CB_TXRDY] = !hold_full_q;
        ctrl_rd[FSP_CB_OVF] = ovf_q;
        ctrl_rd[FSP_CB_PKTRDY] = rxf_full;
        ctrl_rd[FSP_CB_RXRDY] = !rxf_empty;
    end

    // read mux; unmapped words read zero
    always_comb
    begin
        rd_val = 32'h0000_0000;
        unique case (ph_idx_q)
            FSP_IDX_CTRL: rd_val[15:0] = ctrl_rd;
            FSP_IDX_DIV: rd_val[DIV_W-1:0] = div_q;
            FSP_IDX_GAP: rd_val[7:0] = gap_q;
            FSP_IDX_DATA: rd_val[7:0] = rxf_mem[rxf_rd_q];
            FSP_IDX_RXBASE: rd_val[15:0] = rx_base_q;
            FSP_IDX_RXLEN: rd_val[CNT_W-1:0] = rx_cnt_q;
            FSP_IDX_TXBASE: rd_val[15:0] = tx_base_q;
            FSP_IDX_TXLEN: rd_val[CNT_W-1:0] = tx_cnt_q;
            default: rd_val = 32'h0000_0000;
        endcase
    end

    // ======================================================
    // plain configuration registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_q <= FSP_CTRL_RST;
            div_q <= FSP_DIV_RST;
            gap_q <= FSP_GAP_RST;
            rx_base_q <= 16'h0000;
            tx_base_q <= 16'h0000;
        end
        else if (wr_stb)
        begin
            unique case (ph_idx_q)
                FSP_IDX_CTRL: ctrl_q <= wdat & FSP_CTRL_RW_MASK;
                FSP_IDX_DIV: div_q <= wdat[DIV_W-1:0];
                FSP_IDX_GAP: gap_q <= wdat[7:0];
                FSP_IDX_RXBASE: rx_base_q <= wdat;
                FSP_IDX_TXBASE: tx_base_q <= wdat;
                default: ctrl_q <= ctrl_q;
            endcase
        end
    end

    assign port_on = ctrl_q[FSP_CB_EN];

    // receive event: packet-ready or not-empty, gated by its enable
    assign receive_event_line = ctrl_q[FSP_CB_RXIE] &&
        (ctrl_q[FSP_CB_PKT] ? rxf_full : !rxf_empty);

    // ======================================================
    // sticky flags; a hardware set beats a same-cycle clear
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            txdone_q <= 1'b0;
            rxdone_q <= 1'b0;
            ovf_q <= 1'b0;
        end
        else
        begin
            if (mem_rd_done && tx_cnt_q == '0)
                txdone_q <= 1'b1;
            else if (wr_stb && ph_idx_q == FSP_IDX_CTRL && wdat[FSP_CB_TXDONE])
                txdone_q <= 1'b0;
            if (mem_wr_done && rx_cnt_q == '0)
                rxdone_q <= 1'b1;
            else if (wr_stb && ph_idx_q == FSP_IDX_CTRL && wdat[FSP_CB_RXDONE])
                rxdone_q <= 1'b0;
            if (rxf_push && rxf_full)
                ovf_q <= 1'b1;
            else if (wr_stb && ph_idx_q == FSP_IDX_CTRL && wdat[FSP_CB_OVF])
                ovf_q <= 1'b0;
        end
    end

    // ======================================================
    // receive sampler; stop checked once, extra stop bits are idle
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rx_state_q <= FSP_IDLE;
            rx_timer_q <= '0;
            rx_bit_q <= 4'h0;
            rx_shift_q <= 8'h00;
            rx_byte_q <= 8'h00;
            rx_got_q <= 1'b0;
        end
        else
        begin
            rx_got_q <= 1'b0;
            if (!port_on)
                rx_state_q <= FSP_IDLE;
            else if (rx_state_q == FSP_IDLE)
            begin
                if (!serial_rx)
                begin
                    rx_timer_q <= div_q >> 1; // aim at mid-bit
                    rx_state_q <= FSP_START;
                end
            end
            else if (rx_timer_q != '0)
                rx_timer_q <= rx_timer_q - 1'b1;
            else
            begin
                rx_timer_q <= div_q;
                unique case (rx_state_q)
                    FSP_START:
                    begin
                        // a glitch shorter than half a bit is dropped
                        rx_bit_q <= FSP_LAST_BIT;
                        rx_state_q <= serial_rx ? FSP_IDLE : FSP_DATA;
                    end
                    FSP_DATA:
                    begin
                        rx_shift_q <= {serial_rx, rx_shift_q[7:1]};
                        rx_bit_q <= rx_bit_q - 1'b1;
                        if (rx_bit_q == 4'h0)
                            rx_state_q <= FSP_STOP;
                    end
                    FSP_STOP:
                    begin
                        // framing errors are discarded silently
                        rx_byte_q <= rx_shift_q;
                        rx_got_q <= serial_rx;
                        rx_state_q <= FSP_IDLE;
                    end
                    FSP_IDLE:
                        rx_state_q <= FSP_IDLE;
                endcase
            end
        end
    end

    // ======================================================
    // eight-byte receive fifo, shared by byte and block receive
    assign rxf_full = (rxf_cnt_q == RXF_FULL);
    assign rxf_empty = (rxf_cnt_q == '0);
    assign rxf_push = rx_got_q;
    assign cpu_pop = rd_stb && ph_idx_q == FSP_IDX_DATA && !rxf_empty && !rx_act_q;
    assign rxf_pop = cpu_pop || mem_wr_done;

    always_ff @(posedge hclk)
    begin
        if (rxf_push && !rxf_full)
            rxf_mem[rxf_wr_q] <= rx_byte_q;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rxf_rd_q <= '0;
            rxf_wr_q <= '0;
            rxf_cnt_q <= '0;
        end
        else
        begin
            if (rxf_push && !rxf_full)
                rxf_wr_q <= rxf_wr_q + 1'b1;
            if (rxf_pop)
                rxf_rd_q <= rxf_rd_q + 1'b1;
            rxf_cnt_q <= rxf_cnt_q + (PW+1)'(rxf_push && !rxf_full) - (PW+1)'(rxf_pop);
        end
    end

    // ======================================================
    // block engines: counters, pointers and memory requests
    // receive drain has priority; its fifo can overflow, fetch can wait
    assign mem_wr_done = mem_cmd.req && mem_gnt && mem_cmd.we;
    assign mem_rd_done = rd_pend_q;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            mem_cmd <= '0;
            rd_pend_q <= 1'b0;
            rx_act_q <= 1'b0;
            tx_act_q <= 1'b0;
            rx_cnt_q <= FSP_CNT_RST;
            tx_cnt_q <= FSP_CNT_RST;
            rx_ptr_q <= 16'h0000;
            tx_ptr_q <= 16'h0000;
        end
        else
        begin
            rd_pend_q <= mem_cmd.req && mem_gnt && !mem_cmd.we;
            if (mem_cmd.req && mem_gnt)
                mem_cmd.req <= 1'b0;
            else if (!mem_cmd.req && !rd_pend_q && port_on)
            begin
                if (rx_act_q && !rxf_empty && !mem_wr_done)
                begin
                    mem_cmd.req <= 1'b1;
                    mem_cmd.we <= 1'b1;
                    mem_cmd.addr <= rx_ptr_q;
                    mem_cmd.wdata <= rxf_mem[rxf_rd_q];
                end
                else if (tx_act_q && !hold_full_q)
                begin
                    mem_cmd.req <= 1'b1;
                    mem_cmd.we <= 1'b0;
                    mem_cmd.addr <= tx_ptr_q;
                end
            end
            // receive side advance and completion
            if (wr_stb && ph_idx_q == FSP_IDX_RXLEN)
            begin
                rx_cnt_q <= wdat[CNT_W-1:0];
                rx_ptr_q <= rx_base_q;
                rx_act_q <= 1'b1;
            end
            else if (mem_wr_done)
            begin
                rx_cnt_q <= rx_cnt_q - 1'b1;
                rx_ptr_q <= rx_ptr_q + 1'b1;
                if (rx_cnt_q == '0)
                    rx_act_q <= 1'b0;
            end
            // transmit side advance and completion
            if (wr_stb && ph_idx_q == FSP_IDX_TXLEN)
            begin
                tx_cnt_q <= wdat[CNT_W-1:0];
                tx_ptr_q <= tx_base_q;
                tx_act_q <= 1'b1;
            end
            else if (mem_rd_done)
            begin
                tx_cnt_q <= tx_cnt_q - 1'b1;
                tx_ptr_q <= tx_ptr_q + 1'b1;
                if (tx_cnt_q == '0)
                    tx_act_q <= 1'b0;
            end
        end
    end

    // ======================================================
    // one-byte transmit holding stage in front of the shifter
    assign launch = hold_full_q && !tx_busy && port_on;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hold_full_q <= 1'b0;
            hold_blk_q <= 1'b0;
            hold_data_q <= 8'h00;
        end
        else if (mem_rd_done)
        begin
            hold_full_q <= 1'b1;
            hold_blk_q <= 1'b1;
            hold_data_q <= mem_rdata;
        end
        else if (wr_stb && ph_idx_q == FSP_IDX_DATA && !hold_full_q)
        begin
            hold_full_q <= 1'b1;
            hold_blk_q <= 1'b0;
            hold_data_q <= wdat[7:0];
        end
        else if (launch)
            hold_full_q <= 1'b0;
    end

    // stop time: gap minus seven in block mode (at least one), else bit 5
    always_comb
    begin
        if (hold_blk_q)
            stop_bits = (gap_q > FSP_GAP_BIAS) ? gap_q - FSP_GAP_BIAS : FSP_STOP_ONE;
        else
            stop_bits = ctrl_q[FSP_CB_ONESTOP] ? FSP_STOP_ONE : FSP_STOP_TWO;
    end

    fsp_tx_shift #(
        .DIV_W(DIV_W)
    ) u_tx (
        .hclk(hclk),
        .hresetn(hresetn),
        .port_on(port_on),
        .divisor(div_q),
        .stop_bits(stop_bits),
        .launch(launch),
        .launch_data(hold_data_q),
        .busy(tx_busy),
        .line_out(serial_tx)
    );

endmodule

// *** verilog/fsp_tx_shift.sv ***
`timescale 1ns/1ns
module fsp_tx_shift #(
    parameter int DIV_W = 13
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // control
    input wire logic port_on,
    input wire logic [DIV_W-1:0] divisor,
    input wire logic [7:0] stop_bits,
    // byte launch
    input wire logic launch,
    input wire logic [7:0] launch_data,
    output logic busy,
    // line
    output logic line_out
);
    import fsp_pkg::*;

    fsp_line_e state_q;
    logic [DIV_W-1:0] timer_q;
    logic [3:0] bit_q;
    logic [7:0] shift_q;
    logic [7:0] stops_q;

    // launch is only taken while idle, so busy doubles as not-ready
    assign busy = (state_q != FSP_IDLE);

    // ======================================================
    // frame sequencer: start, eight data lsb first, stop/idle time
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_q <= FSP_IDLE;
            timer_q <= '0;
            bit_q <= 4'h0;
            shift_q <= 8'h00;
            stops_q <= 8'h00;
            line_out <= 1'b1;
        end
        else if (state_q == FSP_IDLE)
        begin
            line_out <= 1'b1;
            if (launch && port_on)
            begin
                shift_q <= launch_data;
                stops_q <= stop_bits;
                timer_q <= divisor;
                line_out <= 1'b0;
                state_q <= FSP_START;
            end
        end
        else if (!port_on)
        begin
            // dropping the enable aborts the frame and idles the line
            state_q <= FSP_IDLE;
            line_out <= 1'b1;
        end
        else if (timer_q != '0)
        begin
            timer_q <= timer_q - 1'b1;
        end
        else
        begin
            timer_q <= divisor;
            unique case (state_q)
                FSP_START:
                begin
                    line_out <= shift_q[0];
                    shift_q <= {1'b0, shift_q[7:1]};
                    bit_q <= FSP_LAST_BIT;
                    state_q <= FSP_DATA;
                end
                FSP_DATA:
                begin
                    if (bit_q == 4'h0)
                    begin
                        line_out <= 1'b1;
                        state_q <= FSP_STOP;
                    end
                    else
                    begin
                        line_out <= shift_q[0];
                        shift_q <= {1'b0, shift_q[7:1]};
                        bit_q <= bit_q - 1'b1;
                    end
                end
                FSP_STOP:
                begin
                    // stops_q counts whole bit times of high line
                    if (stops_q <= FSP_STOP_ONE)
                        state_q <= FSP_IDLE;
                    else
                        stops_q <= stops_q - 1'b1;
                end
                FSP_IDLE:
                begin
                    state_q <= FSP_IDLE;
                end
            endcase
        end
    end

endmodule
